// File: cal_ctrl_model.sv
`timescale 1ns/10ps

module cal_ctrl_model (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // bench request
    input wire logic poll_go,
    output logic [7:0] polled,
    // instrument bus
    input wire logic [7:0] spoll_byte,
    output logic spoll
);
    logic wait_r;

    // one-cycle poll; byte taken only after the device latched it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            spoll <= 1'h0;
            wait_r <= 1'h0;
        end else begin
            spoll <= poll_go;
            wait_r <= spoll;
        end
    end

    // captured status byte kept until the next poll
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            polled <= 8'h00;
        end else if (wait_r) begin
            polled <= spoll_byte;
        end
    end

endmodule // cal_ctrl_model

// File: cal_status.sv
`timescale 1ns/10ps

module cal_status
    import cal_status_pkg::*;
#(
    parameter int QDEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register bus
    input wire apb_req_s apb_req,
    output apb_rsp_s apb_rsp,
    // calibration engine
    input wire cal_evt_s cal_evt,
    input wire logic step_busy,
    // instrument bus side
    input wire logic spoll,
    output logic [7:0] spoll_byte,
    output logic srq
);

    localparam int PW = $clog2(QDEPTH);

    // refuse depths the pointer logic cannot serve, at elaboration
    if (QDEPTH < 2 || (1 << PW) != QDEPTH) begin : g_bad_depth
        $error("QDEPTH must be a power of two, at least 2");
    end

    // registers
    logic [7:0] sre_r;
    logic [7:0] ese_r;
    logic [7:0] esr_r;
    logic [NSRC-1:0] pend_r;
    logic [4:0] dc_pt_r;
    logic [4:0] ac_pt_r;
    logic signed [15:0] mem_r [QDEPTH];
    logic [PW:0] wptr_r;
    logic [PW:0] rptr_r;
    logic mav_r;
    logic opc_arm_r;
    logic opcq_arm_r;
    logic rqs_r;
    logic mss_d_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [7:0] spoll_byte_r;

    // combinational helpers
    logic act;
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic cls;
    logic opc_cmd;
    logic opcq_cmd;
    logic esr_rd;
    logic errq_rd;
    logic outq_rd;
    logic q_empty;
    logic q_full;
    logic pop;
    logic push;
    logic signed [15:0] push_code;
    logic [NSRC-1:0] new_src;
    logic [NSRC-1:0] serve;
    logic opc_done;
    logic opcq_done;
    logic [7:0] stb;
    logic mss;
    logic mapped;
    logic cmd_wr;
    logic [31:0] rdata_nxt;

    // apb access: act on the first access edge, one wait state
    assign act = apb_req.psel && apb_req.penable && !pready_r;
    assign wr = act && apb_req.pwrite;
    assign rd = act && !apb_req.pwrite;
    assign addr = apb_req.paddr[4:0];
    assign mapped = (apb_req.paddr[31:5] == 27'h0000000) && (addr[1:0] == 2'h0) && (addr <= OFF_OUTQ);

    // decoded side effects
    assign cmd_wr = wr && mapped && (addr == OFF_CMD);
    assign cls = cmd_wr && apb_req.pwdata[CMD_CLS];
    assign opc_cmd = cmd_wr && apb_req.pwdata[CMD_OPC];
    assign opcq_cmd = cmd_wr && apb_req.pwdata[CMD_OPCQ];
    assign esr_rd = rd && mapped && (addr == OFF_ESR);
    assign errq_rd = rd && mapped && (addr == OFF_ERRQ);
    assign outq_rd = rd && mapped && (addr == OFF_OUTQ);

    // queue state
    assign q_empty = (wptr_r == rptr_r);
    assign q_full = (wptr_r[PW] != rptr_r[PW]) && (wptr_r[PW-1:0] == rptr_r[PW-1:0]);
    assign pop = errq_rd && !q_empty;

    // new error sources this cycle, out-of-range point numbers dropped
    assign new_src = {
        cal_evt.questionable,
        cal_evt.lost_card_dates,
        cal_evt.lost_card,
        cal_evt.lost_dates,
        cal_evt.lost_dc,
        cal_evt.lost_ac,
        cal_evt.data_invalid,
        cal_evt.due_unset,
        cal_evt.date_unset,
        cal_evt.freq_fail,
        cal_evt.ac_fail && (cal_evt.ac_point <= POINT_MAX),
        cal_evt.dc_fail && (cal_evt.dc_point <= POINT_MAX)
    };

    // lowest pending source is served first, one per cycle
    assign serve = pend_r & (~pend_r + NSRC'(1));
    assign push = |serve;

    // map the served source onto its error number
    always_comb begin
        push_code = ERR_NONE;
        case (1'b1)
            serve[0]: push_code = ERR_DC_BASE + 16'(dc_pt_r);
            serve[1]: push_code = ERR_AC_BASE + 16'(ac_pt_r);
            serve[2]: push_code = ERR_FREQ_1V10HZ;
            serve[3]: push_code = ERR_DATE_UNSET;
            serve[4]: push_code = ERR_DUE_UNSET;
            serve[5]: push_code = ERR_DATA_INVALID;
            serve[6]: push_code = ERR_LOST_AC;
            serve[7]: push_code = ERR_LOST_DC;
            serve[8]: push_code = ERR_LOST_DATES;
            serve[9]: push_code = ERR_LOST_CARD;
            serve[10]: push_code = ERR_LOST_CARD_DATES;
            serve[11]: push_code = ERR_QUESTIONABLE;
            default: push_code = ERR_NONE;
        endcase
    end

    // completion of the armed step once the engine goes idle
    assign opc_done = opc_arm_r && !step_busy;
    assign opcq_done = opcq_arm_r && !step_busy;

    // status byte assembly
    always_comb begin
        stb = 8'h00;
        stb[STB_EAV] = !q_empty;
        stb[STB_MAV] = mav_r;
        stb[STB_ESB] = |(esr_r & ese_r);
        mss = |(stb & sre_r);
        stb[STB_RQS] = mss;
    end

    // pending sources, one flag each; a new event wins over its own service
    for (genvar i = 0; i < NSRC; i++) begin : g_pend
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                pend_r[i] <= 1'b0;
            end else if (new_src[i]) begin
                pend_r[i] <= 1'b1;
            end else if (serve[i]) begin
                pend_r[i] <= 1'b0;
            end
        end
    end

    // point number of the last dc failure; a second one before service overwrites
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dc_pt_r <= 5'h00;
        end else if (cal_evt.dc_fail) begin
            dc_pt_r <= cal_evt.dc_point;
        end
    end

    // point number of the last ac failure, same overwrite limitation
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ac_pt_r <= 5'h00;
        end else if (cal_evt.ac_fail) begin
            ac_pt_r <= cal_evt.ac_point;
        end
    end

    // error queue storage; overflow replaces the newest entry, unless a pop or clear status frees room
    always_ff @(posedge clk) begin
        if (push) begin
            if (q_full && !pop && !cls) begin
                mem_r[PW'(wptr_r - (PW+1)'(1))] <= ERR_QUEUE_OVERFLOW;
            end else begin
                mem_r[wptr_r[PW-1:0]] <= push_code;
            end
        end
    end

    // write pointer; a push that meets clear status still lands in the emptied queue
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wptr_r <= '0;
        end else if (cls) begin
            wptr_r <= wptr_r + (PW+1)'(push);
        end else if (push && (!q_full || pop)) begin
            wptr_r <= wptr_r + (PW+1)'(1);
        end
    end

    // read pointer; clear status drops every stored entry
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rptr_r <= '0;
        end else if (cls) begin
            rptr_r <= wptr_r;
        end else if (pop) begin
            rptr_r <= rptr_r + (PW+1)'(1);
        end
    end

    // service request enable; the request bit itself cannot be enabled
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sre_r <= SRE_RST;
        end else if (wr && mapped && (addr == OFF_SRE)) begin
            sre_r <= apb_req.pwdata[7:0] & ~(8'h01 << STB_RQS);
        end
    end

    // standard event enable
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ese_r <= ESE_RST;
        end else if (wr && mapped && (addr == OFF_ESE)) begin
            ese_r <= apb_req.pwdata[7:0];
        end
    end

    // event register: read or clear status wipes it, a set in the same cycle survives
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            esr_r <= ESR_RST;
        end else begin
            esr_r <= ((esr_rd || cls) ? 8'h00 : esr_r)
                | (8'(push) << ESR_DDE)
                | (8'(opc_done) << ESR_OPC);
        end
    end

    // completion command arming; cleared once reported or by clear status
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            opc_arm_r <= 1'b0;
        end else if (opc_cmd) begin
            opc_arm_r <= 1'b1;
        end else if (opc_done || cls) begin
            opc_arm_r <= 1'b0;
        end
    end

    // completion query arming; the controller only issues a new step after completion
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            opcq_arm_r <= 1'b0;
        end else if (opcq_cmd) begin
            opcq_arm_r <= 1'b1;
        end else if (opcq_done || cls) begin
            opcq_arm_r <= 1'b0;
        end
    end

    // single-byte output queue holding the ascii one
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mav_r <= 1'b0;
        end else if (opcq_done) begin
            mav_r <= 1'b1;
        end else if (outq_rd) begin
            mav_r <= 1'b0;
        end
    end

    // summary of the previous cycle, idle low like the summary after reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mss_d_r <= 1'b0;
        end else begin
            mss_d_r <= mss;
        end
    end

    // request latch: set on a rising summary, cleared by a serial poll
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rqs_r <= 1'b0;
        end else if (mss && !mss_d_r) begin
            rqs_r <= 1'b1;
        end else if (spoll || cls || !mss) begin
            rqs_r <= 1'b0;
        end
    end

    // serial poll answer carries the request latch rather than the live summary
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            spoll_byte_r <= 8'h00;
        end else if (spoll) begin
            spoll_byte_r <= (stb & ~(8'h01 << STB_RQS)) | (8'(rqs_r) << STB_RQS);
        end
    end

    // apb handshake: one wait state, refused places flagged alongside pready
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= act;
            pslverr_r <= act && !mapped;
        end
    end

    // read data held until the next read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata_r <= 32'h00000000;
        end else if (rd) begin
            prdata_r <= rdata_nxt;
        end
    end

    // addressed register; refused and write-only places read zero
    always_comb begin
        rdata_nxt = 32'h00000000;
        if (mapped) begin
            case (addr)
                OFF_STB: rdata_nxt = {24'h000000, stb};
                OFF_SRE: rdata_nxt = {24'h000000, sre_r};
                OFF_ESE: rdata_nxt = {24'h000000, ese_r};
                OFF_ESR: rdata_nxt = {24'h000000, esr_r};
                OFF_ERRQ: rdata_nxt = q_empty ? 32'(ERR_NONE) : 32'(mem_r[rptr_r[PW-1:0]]);
                OFF_OUTQ: rdata_nxt = mav_r ? {24'h000000, OPC_ASCII_ONE} : 32'h00000000;
                default: rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // outputs straight from flip-flops
    assign apb_rsp.pready = pready_r;
    assign apb_rsp.pslverr = pslverr_r;
    assign apb_rsp.prdata = prdata_r;
    assign spoll_byte = spoll_byte_r;
    assign srq = rqs_r;

endmodule // cal_status

// File: cal_status_monitor.sv
`timescale 1ns/10ps

module cal_status_monitor
    import cal_status_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register bus
    input wire apb_req_s apb_req,
    input wire apb_rsp_s apb_rsp,
    // engine and instrument bus
    input wire cal_evt_s cal_evt,
    input wire logic step_busy,
    input wire logic spoll,
    input wire logic [7:0] spoll_byte,
    input wire logic srq
);
    logic take;
    logic bad;
    logic rd;
    logic [7:0] sre_sh_r;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // access is taken on the edge before pready
    assign take = apb_req.psel && apb_req.penable && !apb_rsp.pready;
    assign bad = apb_req.paddr[31:5] != 27'h0 || apb_req.paddr[1:0] != 2'h0 || apb_req.paddr[4:0] > OFF_OUTQ;
    assign rd = take && !apb_req.pwrite && !bad;

    // shadow of the request mask, refused writes ignored
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sre_sh_r <= 8'h00;
        end else if (take && apb_req.pwrite && !bad && apb_req.paddr[4:0] == OFF_SRE) begin
            sre_sh_r <= apb_req.pwdata[7:0];
        end
    end

    wait_state_a: assert property (take |=> apb_rsp.pready)
        else $error("access not answered after one wait state");
    ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready held longer than one cycle");
    unmapped_err_a: assert property (take && bad |=> apb_rsp.pslverr)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (take && !bad |=> !apb_rsp.pslverr)
        else $error("mapped access refused");
    bad_read_a: assert property (take && bad && !apb_req.pwrite |=> apb_rsp.prdata == 32'h0)
        else $error("refused read returned data");
    errq_sign_a: assert property (rd && apb_req.paddr[4:0] == OFF_ERRQ |=>
        apb_rsp.prdata[31:16] == {16{apb_rsp.prdata[15]}}) else $error("error number not sign extended");
    outq_val_a: assert property (rd && apb_req.paddr[4:0] == OFF_OUTQ |=>
        apb_rsp.prdata == 32'h0 || apb_rsp.prdata == {24'h0, OPC_ASCII_ONE}) else $error("bad output queue value");
    stb_bits_a: assert property (rd && apb_req.paddr[4:0] == OFF_STB |=>
        (apb_rsp.prdata & 32'hFFFFFF8B) == 32'h0) else $error("status byte has stray bits");
    poll_bits_a: assert property ((spoll_byte & 8'h8B) == 8'h00)
        else $error("polled byte has stray bits");
    srq_mask_a: assert property ((sre_sh_r == 8'h00) [*4] |-> !srq)
        else $error("service request with empty mask");

endmodule // cal_status_monitor

bind cal_status cal_status_monitor u_mon (.clk(clk), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .cal_evt(cal_evt), .step_busy(step_busy), .spoll(spoll), .spoll_byte(spoll_byte), .srq(srq));

// File: cal_status_pkg.sv
package cal_status_pkg;

    // register byte offsets on the apb window
    localparam logic [4:0] OFF_STB = 5'h00;
    localparam logic [4:0] OFF_SRE = 5'h04;
    localparam logic [4:0] OFF_ESE = 5'h08;
    localparam logic [4:0] OFF_ESR = 5'h0C;
    localparam logic [4:0] OFF_ERRQ = 5'h10;
    localparam logic [4:0] OFF_CMD = 5'h14;
    localparam logic [4:0] OFF_OUTQ = 5'h18;

    // command register bits
    localparam int CMD_CLS = 0;
    localparam int CMD_OPC = 1;
    localparam int CMD_OPCQ = 2;

    // status byte bit positions
    localparam int STB_EAV = 2;
    localparam int STB_MAV = 4;
    localparam int STB_ESB = 5;
    localparam int STB_RQS = 6;

    // standard event register bit positions
    localparam int ESR_OPC = 0;
    localparam int ESR_DDE = 3;

    // reset values
    localparam logic [7:0] SRE_RST = 8'h00;
    localparam logic [7:0] ESE_RST = 8'h00;
    localparam logic [7:0] ESR_RST = 8'h00;

    // ascii answer of the completion query
    localparam logic [7:0] OPC_ASCII_ONE = 8'h31;

    // error numbers
    localparam logic signed [15:0] ERR_NONE = 16'sh0000;
    localparam logic signed [15:0] ERR_DC_BASE = 16'sh0190;
    localparam logic signed [15:0] ERR_DATE_UNSET = 16'sh01B6;
    localparam logic signed [15:0] ERR_DUE_UNSET = 16'sh01B7;
    localparam logic signed [15:0] ERR_AC_BASE = 16'sh01C2;
    localparam logic signed [15:0] ERR_FREQ_1V10HZ = 16'sh01F3;
    localparam logic signed [15:0] ERR_DATA_INVALID = 16'sh01F4;
    localparam logic signed [15:0] ERR_LOST_AC = 16'sh0201;
    localparam logic signed [15:0] ERR_LOST_DC = 16'sh0202;
    localparam logic signed [15:0] ERR_LOST_DATES = 16'sh0203;
    localparam logic signed [15:0] ERR_LOST_CARD = 16'sh0206;
    localparam logic signed [15:0] ERR_LOST_CARD_DATES = 16'sh0207;
    localparam logic signed [15:0] ERR_QUESTIONABLE = 16'sh0262;
    localparam logic signed [15:0] ERR_QUEUE_OVERFLOW = -16'sh015E;

    // highest calibration point index per dc and ac group
    localparam logic [4:0] POINT_MAX = 5'h19;

    // number of event sources that feed the queue
    localparam int NSRC = 12;

    // events raised by the calibration engine, one-cycle pulses
    typedef struct packed {
        logic dc_fail;
        logic [4:0] dc_point;
        logic ac_fail;
        logic [4:0] ac_point;
        logic freq_fail;
        logic date_unset;
        logic due_unset;
        logic data_invalid;
        logic lost_ac;
        logic lost_dc;
        logic lost_dates;
        logic lost_card;
        logic lost_card_dates;
        logic questionable;
    } cal_evt_s;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    // apb answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

endpackage

// File: calibration_status_reporting_tb_top.sv
`timescale 1ns/10ps

module calibration_status_reporting_tb_top
    import cal_status_pkg::*;
;
    localparam int CODES [12] = '{400, 450, 499, 438, 439, 500, 513, 514, 515, 518, 519, 610};
    logic clk, resetn, step_busy, poll_go, spoll, srq, er;
    logic [7:0] spoll_byte, polled, esr_m;
    logic [31:0] rd;
    apb_req_s req;
    apb_rsp_s rsp;
    cal_evt_s ev;
    int bad_count, checks, mq[$];

    cal_status #(.QDEPTH(8)) DUT (.clk(clk), .resetn(resetn), .apb_req(req), .apb_rsp(rsp), .cal_evt(ev),
        .step_busy(step_busy), .spoll(spoll), .spoll_byte(spoll_byte), .srq(srq));
    cal_ctrl_model u_ctrl (.clk(clk), .resetn(resetn), .poll_go(poll_go), .polled(polled),
        .spoll_byte(spoll_byte), .spoll(spoll));

    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // one apb transfer; held until pready seen at an edge
    task automatic apb(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: {27'h0, a}, pwdata: d};
        @(posedge clk);
        req.penable <= 1'h1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'h1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'h0;
        req.penable <= 1'h0;
    endtask

    function automatic cal_evt_s mk(input int s, input logic [4:0] pt);
        if (s == 0) mk = cal_evt_s'({1'h1, pt, 16'h0});
        else if (s == 1) mk = cal_evt_s'({6'h0, 1'h1, pt, 10'h0});
        else mk = cal_evt_s'(22'h1 << (11 - s));
    endfunction

    // pulse sources; model queues them lowest source first
    task automatic fire(input cal_evt_s e);
        logic [21:0] b;
        int p;
        b = e;
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= '0;
        for (int s = 0; s < 12; s++) begin
            p = s == 0 ? int'(b[20:16]) : s == 1 ? int'(b[14:10]) : 0;
            if ((s < 2 ? b[21 - 6 * s] : b[11 - s]) && p <= int'(POINT_MAX)) begin
                if (mq.size() == 8) begin
                    mq[7] = int'(ERR_QUEUE_OVERFLOW); // full: newest entry becomes the overflow mark
                end else begin
                    mq.push_back(CODES[s] + p);
                end
                esr_m |= 8'h08;
            end
        end
        repeat (16) @(posedge clk);
    endtask

    task automatic rerr();
        apb(1'h0, OFF_ERRQ, 32'h0);
        chk("error queue", rd, mq.size() > 0 ? 32'(mq.pop_front()) : 32'h0);
    endtask

    task automatic poll();
        @(posedge clk);
        poll_go <= 1'h1;
        @(posedge clk);
        poll_go <= 1'h0;
        repeat (4) @(posedge clk);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog well beyond the several hundred cycles the run needs
    initial begin
        #50000;
        bad_count++;
        wrap_up();
    end

    initial begin
        {resetn, step_busy, poll_go, esr_m, bad_count, checks} = '0;
        req = '0;
        ev = '0;
        void'($urandom(32'h6D68));
        repeat (5) @(posedge clk);
        resetn <= 1'h1;
        // reset values, then refused places
        for (int i = 0; i < 7; i++) begin
            apb(1'h0, 5'(i * 4), 32'h0);
            chk("reset value", rd, 32'h0);
        end
        apb(1'h0, 5'h1C, 32'h0);
        chk("unmapped read", {er, rd[30:0]}, 32'h80000000);
        apb(1'h1, 5'h06, 32'hFF);
        chk("misaligned write", 32'(er), 32'h1);
        // every error source, each on its own
        for (int s = 0; s < 12; s++) begin
            fire(mk(s, 5'($urandom_range(25))));
            apb(1'h0, OFF_STB, 32'h0);
            chk("eav set", 32'(rd[STB_EAV]), 32'h1);
            rerr();
            apb(1'h0, OFF_STB, 32'h0);
            chk("eav clear", 32'(rd[STB_EAV]), 32'h0);
        end
        apb(1'h0, OFF_ESR, 32'h0);
        chk("event register", rd, 32'(esr_m));
        esr_m = 8'h00;
        apb(1'h0, OFF_ESR, 32'h0);
        chk("event cleared", rd, 32'h0);
        // simultaneous sources plus a later one, drained past empty
        fire(cal_evt_s'({1'h1, 5'h19, 16'h0} | 22'h201));
        fire(mk(5, 5'h0));
        repeat (5) rerr();
        // a point past the last one is dropped, then every source at once overflows the queue
        fire(mk(0, 5'h1A));
        rerr();
        fire(cal_evt_s'({1'h1, 5'($urandom_range(25)), 1'h1, 5'($urandom_range(25)), 10'h3FF}));
        repeat (9) rerr();
        // service request on error
        apb(1'h1, OFF_SRE, 32'h4);
        fire(mk(3, 5'h0));
        chk("srq on error", 32'(srq), 32'h1);
        poll();
        chk("polled eav", 32'(polled[STB_EAV]), 32'h1);
        chk("srq after poll", 32'(srq), 32'h0);
        rerr();
        apb(1'h1, OFF_SRE, 32'h0);
        apb(1'h0, OFF_ESR, 32'h0);
        esr_m = 8'h00;
        // completion command while a step runs
        apb(1'h1, OFF_ESE, 32'h1);
        apb(1'h1, OFF_SRE, 32'h20);
        step_busy <= 1'h1;
        apb(1'h1, OFF_CMD, 32'h2);
        repeat (8) @(posedge clk);
        chk("srq while busy", 32'(srq), 32'h0);
        step_busy <= 1'h0;
        repeat (6) @(posedge clk);
        chk("srq on completion", 32'(srq), 32'h1);
        apb(1'h0, OFF_STB, 32'h0);
        chk("event summary", 32'(rd[STB_ESB]), 32'h1);
        apb(1'h0, OFF_ESR, 32'h0);
        chk("completion bit", rd, 32'h1);
        apb(1'h0, OFF_ESR, 32'h0);
        chk("completion cleared", rd, 32'h0);
        chk("srq dropped", 32'(srq), 32'h0);
        // completion query through the output queue
        apb(1'h1, OFF_CMD, 32'h4);
        apb(1'h0, OFF_STB, 32'h0);
        chk("mav set", 32'(rd[STB_MAV]), 32'h1);
        apb(1'h0, OFF_OUTQ, 32'h0);
        chk("ascii one", rd, 32'h31);
        apb(1'h0, OFF_STB, 32'h0);
        chk("mav clear", 32'(rd[STB_MAV]), 32'h0);
        apb(1'h0, OFF_OUTQ, 32'h0);
        chk("output empty", rd, 32'h0);
        // clear status with an error queued and completion pending
        fire(mk(6, 5'h0));
        step_busy <= 1'h1;
        apb(1'h1, OFF_CMD, 32'h2);
        apb(1'h1, OFF_CMD, 32'h1);
        mq.delete();
        step_busy <= 1'h0;
        repeat (6) @(posedge clk);
        apb(1'h0, OFF_ESR, 32'h0);
        chk("esr after clear", rd, 32'h0);
        rerr();
        apb(1'h0, OFF_STB, 32'h0);
        chk("stb after clear", rd, 32'h0);
        wrap_up();
    end

endmodule // calibration_status_reporting_tb_top
